// File: logic/hmseq_consts.vh
`ifndef HMSEQ_CONSTS_VH
`define HMSEQ_CONSTS_VH

// supported homing methods
`define HMSEQ_METHOD_FIRST 4'h7
`define HMSEQ_METHOD_LAST  4'hB
`define HMSEQ_METHOD_NL    4'hB

// start variants: switch active, switch off, restarted after a limit
`define HMSEQ_VAR_ACTIVE 2'h0
`define HMSEQ_VAR_OFF    2'h1
`define HMSEQ_VAR_LIMIT  2'h2

// segment word fields {dir_fwd, fast, end_on_rise, stop_after, last}
`define HMSEQ_SEG_DIR  4
`define HMSEQ_SEG_FAST 3
`define HMSEQ_SEG_ON   2
`define HMSEQ_SEG_STOP 1
`define HMSEQ_SEG_LAST 0

// one-hot state codes
`define HMSEQ_ST_IDLE  6'h01
`define HMSEQ_ST_RUN   6'h02
`define HMSEQ_ST_STOP  6'h04
`define HMSEQ_ST_INDEX 6'h08
`define HMSEQ_ST_DONE  6'h10
`define HMSEQ_ST_ALARM 6'h20

`define HMSEQ_SPEED_W 16
`define HMSEQ_POS_W   32

`endif

// File: logic/hmseq_edge.v
`timescale 1ns/1ps
module hmseq_edge (
  input  wire ref_clk,  // control clock
  input  wire rstn,     // async reset, active low
  input  wire din,      // synchronous level input
  output reg  level_q,  // registered level
  output wire rise,     // one-cycle off-to-on pulse
  output wire fall      // one-cycle on-to-off pulse
);

  // one register per input, so every edge shows exactly once
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      level_q <= 1'b0;
    end else begin
      level_q <= din;
    end
  end

  assign rise = din & ~level_q;
  assign fall = ~din & level_q;

endmodule // hmseq_edge

// File: logic/hmseq_top.v
// Functional notes
// R1 - M7 switch on at start: reverse slow, home on index after switch off
// R2 - M7-10: first positive limit going forward reverses; other limit aborts
// R3 - M7 switch off reverse side: forward fast, stop, reverse slow, home
// R4 - M8 forward side: to positive limit, reverse fast, slow, stop, forward
// R5 - M8 reverse side: forward fast, stop, back slow, forward slow, home
// R6 - M8 switch on: reverse slow, stop at off, forward slow, home at on
// R7 - M9 forward side: limit, reverse fast, stop, back, reverse slow, home
// R8 - M9 reverse side: forward fast, slow, stop at off, reverse slow, home
// R9 - M9 switch on: forward slow, stop at off, reverse slow, home at on
// R10 - M10 forward side: limit, reverse fast, stop, forward slow, home
// R11 - M10 reverse side: fast, slow, stop, back into switch, forward slow
// R12 - M11 forward side: reverse fast, stop at on, forward slow, home
// R13 - M11 reverse side: to negative limit, forward fast, slow at switch on
// R14 - M11: first negative limit reversing turns back; other limit aborts
// R15 - latch position at index as home, stop, done; alarm held until ack
// R16 - speeds from inputs; every switch registered once for edge detection
`timescale 1ns/1ps
`include "hmseq_consts.vh"
module hmseq_top (
  input  wire                      ref_clk,        // 100 MHz control clock
  input  wire                      rstn,           // async reset, active low
  input  wire                      start,          // begin homing, pulse
  input  wire [3:0]                method,         // homing method 7..11
  input  wire                      home_switch,    // home switch level
  input  wire                      positive_limit_switch, // forward limit
  input  wire                      negative_limit_switch, // reverse limit
  input  wire                      index_pulse,    // encoder index
  input  wire                      axis_stopped,   // axis at zero speed
  input  wire [`HMSEQ_POS_W-1:0]   pos_count,      // position counter
  input  wire [`HMSEQ_SPEED_W-1:0] high_speed,     // fast search speed
  input  wire [`HMSEQ_SPEED_W-1:0] low_speed,      // slow search speed
  input  wire                      alarm_ack,      // clears alarm, pulse
  output reg                       move_q,         // motion enabled
  output reg                       dir_fwd_q,      // 1 forward, 0 reverse
  output reg                       speed_high_q,   // fast search active
  output reg  [`HMSEQ_SPEED_W-1:0] speed_q,        // speed command
  output reg                       decel_stop_q,   // decelerate to stop
  output reg                       busy_q,         // homing in progress
  output reg                       done_q,         // home found
  output reg                       alarm_q,        // homing aborted
  output reg  [`HMSEQ_POS_W-1:0]   home_pos_q      // latched home position
);

  ////////////////////////////////////////////////////////////////////////////
  // input edge detection
  wire hsw_lvl;
  wire hsw_rise;
  wire hsw_fall;
  wire pl_rise;
  wire nl_rise;
  wire idx_rise;

  // each input passes one register so an edge is seen once [R16]
  hmseq_edge u_hsw (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .din     (home_switch),
    .level_q (hsw_lvl),
    .rise    (hsw_rise),
    .fall    (hsw_fall)
  );
  hmseq_edge u_pl (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .din     (positive_limit_switch),
    .level_q (),
    .rise    (pl_rise),
    .fall    ()
  );
  hmseq_edge u_nl (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .din     (negative_limit_switch),
    .level_q (),
    .rise    (nl_rise),
    .fall    ()
  );
  hmseq_edge u_idx (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .din     (index_pulse),
    .level_q (),
    .rise    (idx_rise),
    .fall    ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // segment programs: each method is a short list of moves ending on a
  // switch edge; the last move carries on to the next index pulse
  function [4:0] seg_of;
    input [6:0] key; // {method-7, variant, phase}
    begin
      case (key)
        7'h00: seg_of = 5'h01; // m7 on: rev slow to off [R1]
        7'h04: seg_of = 5'h1E; // m7 off: fwd fast to on, stop [R3]
        7'h05: seg_of = 5'h01; // rev slow to off [R3]
        7'h08: seg_of = 5'h0C; // after limit: rev fast to on
        7'h09: seg_of = 5'h01; // rev slow to off
        7'h10: seg_of = 5'h02; // m8 on: rev slow to off, stop [R6]
        7'h11: seg_of = 5'h15; // fwd slow to on [R6]
        7'h14: seg_of = 5'h1E; // m8 off: fwd fast to on, stop [R5]
        7'h15: seg_of = 5'h02; // back slow to off, stop [R5]
        7'h16: seg_of = 5'h15; // fwd slow to on [R5]
        7'h18: seg_of = 5'h0C; // after limit: rev fast to on [R4]
        7'h19: seg_of = 5'h02; // rev slow to off, stop [R4]
        7'h1A: seg_of = 5'h15; // fwd slow to on [R4]
        7'h20: seg_of = 5'h12; // m9 on: fwd slow to off, stop [R9]
        7'h21: seg_of = 5'h05; // rev slow to on [R9]
        7'h24: seg_of = 5'h1C; // m9 off: fwd fast to on [R8]
        7'h25: seg_of = 5'h12; // fwd slow to off, stop [R8]
        7'h26: seg_of = 5'h05; // rev slow to on [R8]
        7'h28: seg_of = 5'h0E; // after limit: rev fast to on, stop [R7]
        7'h29: seg_of = 5'h12; // back slow to off, stop [R7]
        7'h2A: seg_of = 5'h05; // rev slow to on [R7]
        7'h30: seg_of = 5'h11; // m10 on: fwd slow to off
        7'h34: seg_of = 5'h1C; // m10 off: fwd fast to on [R11]
        7'h35: seg_of = 5'h12; // fwd slow to off, stop [R11]
        7'h36: seg_of = 5'h06; // back slow into switch, stop [R11]
        7'h37: seg_of = 5'h11; // fwd slow to off [R11]
        7'h38: seg_of = 5'h0E; // after limit: rev fast to on, stop [R10]
        7'h39: seg_of = 5'h11; // fwd slow to off [R10]
        7'h40: seg_of = 5'h11; // m11 on: fwd slow to off
        7'h44: seg_of = 5'h0E; // m11 off: rev fast to on, stop [R12]
        7'h45: seg_of = 5'h11; // fwd slow to off [R12]
        7'h48: seg_of = 5'h1C; // after limit: fwd fast to on [R13]
        7'h49: seg_of = 5'h12; // fwd slow to off, stop
        7'h4A: seg_of = 5'h06; // back slow into switch, stop
        7'h4B: seg_of = 5'h11; // fwd slow to off
        default: seg_of = 5'h01;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // sequencer registers
  reg [5:0] state_q;
  reg [5:0] state_d;
  reg [2:0] mth_q;
  reg [2:0] mth_d;
  reg [1:0] var_q;
  reg [1:0] var_d;
  reg [1:0] ph_q;
  reg [1:0] ph_d;
  reg       reversed_q;
  reg       reversed_d;
  reg       dir_idx_q;
  reg       dir_idx_d;

  wire [4:0] seg     = seg_of({mth_q, var_q, ph_q});
  wire       seg_fwd = seg[`HMSEQ_SEG_DIR];
  wire       seg_ev  = seg[`HMSEQ_SEG_ON] ? hsw_rise : hsw_fall;
  wire       use_nl  = (mth_q == 3'h4);
  wire       moving  = state_q[1] | state_q[3];
  wire       mv_fwd  = state_q[3] ? dir_idx_q : seg_fwd;

  // the turn-back limit lies in the search direction; meeting it a second
  // time, against the run, or meeting the other limit means the axis is lost
  wire auto_hit  = use_nl ? (nl_rise & ~mv_fwd) : (pl_rise & mv_fwd);
  wire lim_any   = pl_rise | nl_rise;
  wire turn_back = moving & auto_hit & ~reversed_q & state_q[1]; // [R2] [R14]
  wire abort     = moving & lim_any & ~turn_back;                // [R2] [R14]
  wire meth_ok   = (method >= `HMSEQ_METHOD_FIRST) &&
                   (method <= `HMSEQ_METHOD_LAST);
  wire [3:0] mth_off = method - `HMSEQ_METHOD_FIRST;

  // next-state logic
  always @* begin
    state_d    = state_q;
    mth_d      = mth_q;
    var_d      = var_q;
    ph_d       = ph_q;
    reversed_d = reversed_q;
    dir_idx_d  = dir_idx_q;
    case (state_q)
      `HMSEQ_ST_IDLE, `HMSEQ_ST_DONE: begin
        if (start && meth_ok) begin
          state_d    = `HMSEQ_ST_RUN;
          mth_d      = mth_off[2:0];
          var_d      = hsw_lvl ? `HMSEQ_VAR_ACTIVE : `HMSEQ_VAR_OFF;
          ph_d       = 2'h0;
          reversed_d = 1'b0;
        end else if (start) begin
          state_d = `HMSEQ_ST_ALARM;
        end
      end
      `HMSEQ_ST_RUN: begin
        if (abort) begin
          state_d = `HMSEQ_ST_ALARM;                      // [R2] [R14]
        end else if (turn_back) begin
          state_d    = `HMSEQ_ST_STOP;                    // [R2] [R14]
          var_d      = `HMSEQ_VAR_LIMIT;
          ph_d       = 2'h0;
          reversed_d = 1'b1;
        end else if (seg_ev && seg[`HMSEQ_SEG_LAST]) begin
          state_d   = `HMSEQ_ST_INDEX;                    // [R1]
          dir_idx_d = seg_fwd;
        end else if (seg_ev && seg[`HMSEQ_SEG_STOP]) begin
          state_d = `HMSEQ_ST_STOP;
          ph_d    = ph_q + 2'h1;
        end else if (seg_ev) begin
          ph_d = ph_q + 2'h1;                             // slow, no stop
        end
      end
      `HMSEQ_ST_STOP: begin
        // a limit met while braking is not a search event; wait it out
        if (axis_stopped) begin
          state_d = `HMSEQ_ST_RUN;
        end
      end
      `HMSEQ_ST_INDEX: begin
        if (abort) begin
          state_d = `HMSEQ_ST_ALARM;
        end else if (idx_rise) begin
          state_d = `HMSEQ_ST_DONE;                       // [R15]
        end
      end
      `HMSEQ_ST_ALARM: begin
        if (alarm_ack) begin
          state_d = `HMSEQ_ST_IDLE;                       // [R15]
        end
      end
      default: state_d = `HMSEQ_ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state and output registers
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q      <= `HMSEQ_ST_IDLE;
      mth_q        <= 3'h0;
      var_q        <= 2'h0;
      ph_q         <= 2'h0;
      reversed_q   <= 1'b0;
      dir_idx_q    <= 1'b0;
      busy_q       <= 1'b0;
      done_q       <= 1'b0;
      alarm_q      <= 1'b0;
      home_pos_q   <= {`HMSEQ_POS_W{1'b0}};
    end else begin
      state_q    <= state_d;
      mth_q      <= mth_d;
      var_q      <= var_d;
      ph_q       <= ph_d;
      reversed_q <= reversed_d;
      dir_idx_q  <= dir_idx_d;
      // home is the counter value on the qualifying index edge [R15]
      if (state_q[3] && !abort && idx_rise) begin
        home_pos_q <= pos_count;                          // [R15]
      end
      done_q  <= state_d[4];                              // [R15]
      alarm_q <= state_d[5];                              // [R15]
      busy_q  <= state_d[1] | state_d[2] | state_d[3];
    end
  end

  // motion command follows the segment that will be active next cycle
  wire [4:0] seg_n   = seg_of({mth_d, var_d, ph_d});
  wire       run_n   = state_d[1];
  wire       fast_n  = run_n & seg_n[`HMSEQ_SEG_FAST];
  wire       dir_n   = state_d[3] ? dir_idx_d : seg_n[`HMSEQ_SEG_DIR];

  // speed values come from the live inputs so they can be tuned [R16]
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      move_q       <= 1'b0;
      dir_fwd_q    <= 1'b0;
      speed_high_q <= 1'b0;
      speed_q      <= {`HMSEQ_SPEED_W{1'b0}};
      decel_stop_q <= 1'b0;
    end else begin
      move_q       <= run_n | state_d[3];
      dir_fwd_q    <= (run_n | state_d[3]) ? dir_n : dir_fwd_q;
      speed_high_q <= fast_n;
      speed_q      <= (run_n | state_d[3]) ?
                      (fast_n ? high_speed : low_speed) :            // [R16]
                      {`HMSEQ_SPEED_W{1'b0}};
      decel_stop_q <= state_d[2] | state_d[5] |
                      (state_d[4] & ~state_q[4]);                    // [R15]
    end
  end

endmodule // hmseq_top

// File: sim/hmseq_top_sva.sv
`timescale 1ns/1ps
module hmseq_chk (
  input wire        ref_clk,
  input wire        rstn,
  input wire        start,
  input wire [3:0]  method,
  input wire        home_switch,
  input wire        positive_limit_switch,
  input wire        negative_limit_switch,
  input wire        index_pulse,
  input wire        axis_stopped,
  input wire [31:0] pos_count,
  input wire [15:0] high_speed,
  input wire [15:0] low_speed,
  input wire        alarm_ack,
  input wire        move_q,
  input wire        dir_fwd_q,
  input wire        speed_high_q,
  input wire [15:0] speed_q,
  input wire        decel_stop_q,
  input wire        busy_q,
  input wire        done_q,
  input wire        alarm_q,
  input wire [31:0] home_pos_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // a start is only taken while idle or done
  wire go = start && !busy_q && !alarm_q;
  wire ok = method >= 4'h7 && method <= 4'hB;
  ////////////////////////////////
  // home found: one braking cycle, then done is held
  sequence s_done;
    decel_stop_q && !move_q && !busy_q && speed_q == 16'h0000
    ##1 !decel_stop_q && done_q;
  endsequence
  // index rose one cycle back and its position was kept
  sequence s_latch;
    $past(index_pulse) && !$past(index_pulse, 2)
    && home_pos_q == $past(pos_count);
  endsequence
  a_start_motion: assert property (go && ok |=>
    busy_q && move_q && speed_high_q == !$past(home_switch, 2) &&
    dir_fwd_q == ($past(home_switch, 2) ? $past(method) >= 4'h9 :
    $past(method) != 4'hB)) else $error("start motion wrong");
  a_bad_method: assert property (go && !ok |=> alarm_q && !busy_q)
    else $error("bad method not refused");
  a_alarm_hold: assert property (alarm_q && !alarm_ack |=> alarm_q)
    else $error("alarm dropped");
  a_alarm_still: assert property (alarm_q |-> decel_stop_q && !move_q
    && !done_q) else $error("alarm while moving");
  a_done_entry: assert property ($rose(done_q) |-> s_done)
    else $error("done entry wrong");
  a_home_latch: assert property ($rose(done_q) |-> s_latch)
    else $error("home position wrong");
  a_speed_sel: assert property (move_q && $past(move_q) |->
    speed_q == (speed_high_q ? $past(high_speed) : $past(low_speed)))
    else $error("speed wrong");
  a_stop_idle: assert property (busy_q && !move_q |-> decel_stop_q
    && speed_q == 16'h0000) else $error("stop phase wrong");
  a_stop_wait: assert property (busy_q && !move_q |=>
    move_q == $past(axis_stopped)) else $error("stop resume wrong");
  a_limit_react: assert property (move_q &&
    ($rose(positive_limit_switch) || $rose(negative_limit_switch))
    |=> !move_q && decel_stop_q) else $error("limit ignored");
  a_busy_end: assert property ($fell(busy_q) && $past(rstn) |->
    done_q != alarm_q) else $error("busy end wrong");
endmodule // hmseq_chk

// File: sim/hmseq_servo.sv
`timescale 1ns/1ps
module hmseq_servo #(
  parameter HS_LO  = 1000,
  parameter HS_HI  = 1100,
  parameter PL_POS = 2000
) (
  input  wire        ref_clk,
  input  wire        load,
  input  wire [31:0] load_pos,
  input  wire        hs_en,
  input  wire [2:0]  lag,
  input  wire        move_q,
  input  wire        dir_fwd_q,
  input  wire        speed_high_q,
  output wire        home_switch,
  output wire        positive_limit_switch,
  output wire        negative_limit_switch,
  output wire        index_pulse,
  output wire        axis_stopped,
  output wire [31:0] pos_count
);
  integer   pos_q = 0;
  reg [2:0] cnt_q = 3'h0;
  ////////////////////////////////
  // one count a cycle slow, four fast; lag sets how long braking lasts
  always @(posedge ref_clk) begin
    if (load)
      pos_q <= load_pos;
    else if (move_q)
      pos_q <= pos_q + (dir_fwd_q ? 1 : -1) * (speed_high_q ? 4 : 1);
    cnt_q <= move_q ? 3'h0 : (cnt_q == lag ? cnt_q : cnt_q + 3'h1);
  end
  // switches from position; no switch fitted models a missing home
  assign home_switch = hs_en && pos_q >= HS_LO && pos_q <= HS_HI;
  assign positive_limit_switch = pos_q >= PL_POS;
  assign negative_limit_switch = pos_q <= 0;
  assign index_pulse = pos_q[5:0] == 6'h00;
  assign axis_stopped = !move_q && cnt_q == lag;
  assign pos_count = pos_q;
endmodule // hmseq_servo

// File: sim/hmseq_tb_top.sv
`timescale 1ns/1ps
module hmseq_tb_top;
  localparam HS_LO = 1000;
  localparam HS_HI = 1100;
  reg         ref_clk = 1'b0, rstn = 1'b0, start = 1'b0, alarm_ack = 1'b0;
  reg         load = 1'b0, hs_en = 1'b1;
  reg  [3:0]  method = 4'h7;
  reg  [2:0]  lag = 3'h0;
  reg  [15:0] high_speed = 16'h0000, low_speed = 16'h0000;
  reg  [31:0] load_pos = 32'h00000000, seed = 32'h5EF82D97;
  integer     error_cnt = 0, num_checks = 0, p, s;
  wire        home_switch, positive_limit_switch, negative_limit_switch;
  wire        index_pulse, axis_stopped, move_q, dir_fwd_q, speed_high_q;
  wire        decel_stop_q, busy_q, done_q, alarm_q;
  wire [15:0] speed_q;
  wire [31:0] pos_count, home_pos_q;
  hmseq_top hmseq_top_i (.ref_clk(ref_clk), .rstn(rstn), .start(start),
    .method(method), .home_switch(home_switch),
    .positive_limit_switch(positive_limit_switch),
    .negative_limit_switch(negative_limit_switch),
    .index_pulse(index_pulse), .axis_stopped(axis_stopped),
    .pos_count(pos_count), .high_speed(high_speed), .low_speed(low_speed),
    .alarm_ack(alarm_ack), .move_q(move_q), .dir_fwd_q(dir_fwd_q),
    .speed_high_q(speed_high_q), .speed_q(speed_q),
    .decel_stop_q(decel_stop_q), .busy_q(busy_q), .done_q(done_q),
    .alarm_q(alarm_q), .home_pos_q(home_pos_q));
  hmseq_servo #(.HS_LO(HS_LO), .HS_HI(HS_HI)) hmseq_servo_i (
    .ref_clk(ref_clk), .load(load), .load_pos(load_pos), .hs_en(hs_en),
    .lag(lag), .move_q(move_q), .dir_fwd_q(dir_fwd_q),
    .speed_high_q(speed_high_q), .home_switch(home_switch),
    .positive_limit_switch(positive_limit_switch),
    .negative_limit_switch(negative_limit_switch),
    .index_pulse(index_pulse), .axis_stopped(axis_stopped),
    .pos_count(pos_count));
  ////////////////////////////////
  always #5 ref_clk = ~ref_clk;
  function [31:0] lfsr(input [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // first index past the switch edge that ends each method's last segment
  function [31:0] exp_home(input [3:0] m);
    case (m)
      4'h7: exp_home = ((HS_LO - 1) / 64) * 64;
      4'h8: exp_home = ((HS_LO + 63) / 64) * 64;
      4'h9: exp_home = (HS_HI / 64) * 64;
      default: exp_home = ((HS_HI + 64) / 64) * 64;
    endcase
  endfunction
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task pulse_ack;
    @(posedge ref_clk);
    #1 alarm_ack = 1'b1;
    @(posedge ref_clk);
    #1 alarm_ack = 1'b0;
  endtask
  // park the axis, random speeds and braking time, one homing run
  task run(input [3:0] m, input [31:0] p, input h, input al);
    integer n;
    seed = lfsr(seed);
    load = 1'b1;
    load_pos = p;
    hs_en = h;
    method = m;
    high_speed = seed[15:0];
    low_speed = seed[31:16];
    lag = seed[2:0];
    @(posedge ref_clk);
    #1 load = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 start = 1'b1;
    @(posedge ref_clk);
    #1 start = 1'b0;
    // look just after each edge so the outputs have settled
    for (n = 0; n < 5000 && done_q !== 1'b1 && alarm_q !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("alarm", alarm_q, al);
    chk("done", done_q, !al);
    if (!al) chk("home", home_pos_q, exp_home(m));
    $display("test method %0h from %0d ended", m, p);
  endtask
  // watchdog: all runs together need far fewer than 40000 cycles
  initial begin
    #400000;
    error_cnt = error_cnt + 1;
    $display("watchdog expired");
    complete_run;
  end
  // methods from all three start places, then aborts and refusals
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 rstn = 1'b1;
    for (s = 0; s < 3; s++) begin
      p = s == 0 ? 1048 : (s == 1 ? 1500 : 500);
      run(4'h7, p, 1'b1, 1'b0);
      run(4'h8, p, 1'b1, 1'b0);
      run(4'h9, p, 1'b1, 1'b0);
      run(4'hA, p, 1'b1, 1'b0);
      run(4'hB, p, 1'b1, 1'b0);
    end
    run(4'h7, 500, 1'b0, 1'b1);
    method = 4'h8;
    start = 1'b1;
    @(posedge ref_clk);
    #1 start = 1'b0;
    chk("refused", {busy_q, alarm_q}, 2'h1);
    pulse_ack;
    chk("ack", alarm_q, 1'h0);
    $display("test start during alarm ended");
    run(4'hB, 1500, 1'b0, 1'b1);
    pulse_ack;
    run(4'h3, 1500, 1'b1, 1'b1);
    pulse_ack;
    complete_run;
  end
endmodule // hmseq_tb_top
bind hmseq_top hmseq_chk hmseq_chk_i (.*);
